// ### cursor_regs.svh
// register offsets, field positions and reset values of the cursor block
`ifndef CURSOR_REGS_SVH
`define CURSOR_REGS_SVH

// ------------------------------------------------------------
// address map (byte addresses, one word each)
// ------------------------------------------------------------
`define CUR_STRIDE 8'h20
`define CUR_SEL_BIT 5
`define CUR_SUB_CFG 3'h0
`define CUR_SUB_BASE 3'h1
`define CUR_SUB_ACTIVE 3'h2
`define CUR_SUB_STATUS 3'h3
`define CUR_SUB_POS_FIRST 3'h4
`define CUR_SUB_POS_LAST 3'h7

// ------------------------------------------------------------
// config fields
// ------------------------------------------------------------
`define CFG_EN_BIT 0
`define CFG_MODE_LSB 1
`define CFG_ORIGIN_BIT 3
`define CFG_PAT_LSB 4
`define CFG_WIDTH 6
`define CFG_RESET 6'h00
`define HI_BYTE_MASK 8'h0f
`define BASE_RESET 12'h000
`define POS_RESET 12'h000

`endif

// ### cursor_pkg.sv
// types shared by the cursor block
package cursor_pkg;
    typedef enum logic [1:0] {M64_3C, M128_2C, M128_1C, M_RSV} cur_mode_e;
    typedef enum logic {F_IDLE, F_RUN} fetch_e;
    typedef struct packed {
        logic [1:0][5:0] cfg;
        logic [1:0][11:0] base;
        logic [1:0][3:0][7:0] pend;
        logic [1:0][11:0] act_x;
        logic [1:0][11:0] act_y;
        logic [1:0][1:0] seq;
        logic [1:0] armed;
        logic ack;
        logic [31:0] rdat;
        fetch_e fst;
        logic fc;
        logic [1:0] fw;
        logic [1:0] row_ok;
        logic [1:0][6:0] row;
        logic [1:0][3:0][31:0] line;
        logic show;
        logic [1:0] color;
    } cursor_s;
endpackage : cursor_pkg

// ### pix_if.sv
// plane bits in, cursor colour out, between core and decoder
`timescale 1ns/10ps
interface pix_if;
    import cursor_pkg::*;
    cur_mode_e mode;
    logic p0;
    logic p1;
    logic show;
    logic [1:0] color;
    modport dec (input mode, input p0, input p1, output show, output color);
    modport core (output mode, output p0, output p1, input show, input color);
endinterface : pix_if

// ### cursor_decode.sv
// pattern bit to cursor colour or transparency
`timescale 1ns/10ps
module cursor_decode (
    pix_if.dec px
);
    import cursor_pkg::*;
    always_comb begin
        px.show = 1'b1;
        px.color = 2'h0;
        case (px.mode)
            M64_3C: begin
                // p0 p1: 00 c0, 01 c1, 10 clear, 11 c3
                px.show = !(px.p0 && !px.p1); // [RULE_03]
                px.color = {px.p0, px.p1}; // [RULE_03]
            end
            M128_2C: begin
                px.color = {1'b1, px.p0}; // [RULE_06]
            end
            M128_1C: begin
                px.show = px.p0; // [RULE_07]
                px.color = 2'h2; // [RULE_07]
            end
            default: begin
                px.show = 1'b0;
            end
        endcase
    end
endmodule : cursor_decode

// ### cursor_core.sv
// two hardware cursors: registers, pattern fetch and pixel overlay
//
// How it works
// [RULE_01] 64x64 three-colour mode addresses four 1 KB patterns in the 4 KB region at base.
// [RULE_02] a 64x64 line is 16 bytes: plane 0 low, plane 0 high, plane 1 low, plane 1 high.
// [RULE_03] 64x64 planes 00, 01, 11 give colours 0, 1, 3 and 10 is transparent.
// [RULE_04] 128x128 two-colour mode addresses two 2 KB patterns in the 4 KB region.
// [RULE_05] a 128x128 line is four words of pixels 31-0 up to 127-96, pattern 1 at 800h.
// [RULE_06] 128x128 two-colour mode shows colour 2 for a 0 bit and colour 3 for a 1 bit.
// [RULE_07] 128x128 one-colour mode is transparent for 0 and shows colour 2 for 1.
// [RULE_08] 128x128 one-colour mode also holds only two 2 KB patterns.
// [RULE_09] each cursor has four byte position registers: x low, x high, y low, y high.
// [RULE_10] a config bit measures position from the active area or the outer border corner.
// [RULE_11] positions are 12-bit two's-complement values.
// [RULE_12] positions are double-buffered and reach the display only at vertical sync.
// [RULE_13] software writes the four position bytes in ascending order.
// [RULE_14] only a complete in-order sequence is moved to the active position at vsync.
// [RULE_15] a pattern-select field picks one of four (64x64) or two (128x128) patterns.
// [RULE_16] a broken sequence is dropped and restarts on a write of the first position byte.
`timescale 1ns/10ps
`include "cursor_regs.svh"
module cursor_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic vsync_i,
    input wire logic line_start_i,
    input wire logic pix_valid_i,
    input wire logic [11:0] hpos_i,
    input wire logic [11:0] vpos_i,
    input wire logic [11:0] border_left_i,
    input wire logic [11:0] border_top_i,
    output logic mem_req_o,
    output logic [23:0] mem_addr_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_data_i,
    output logic cur_show_o,
    output logic [1:0] cur_color_o
);
    import cursor_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic cur_mode_e mode_of(input logic [5:0] cfg);
        mode_of = cur_mode_e'(cfg[`CFG_MODE_LSB +: 2]);
    endfunction : mode_of

    // signed distance of a beam coordinate from the cursor corner
    function automatic logic signed [13:0] rel(input logic [11:0] coord,
        input logic [11:0] pos, input logic [11:0] brd, input logic org);
        logic [13:0] a;
        a = {{2{pos[11]}}, pos} + (org ? 14'h0000 : {2'h0, brd}); // [RULE_10] [RULE_11]
        rel = signed'({2'h0, coord} - a);
    endfunction : rel

    function automatic logic in_span(input logic signed [13:0] d, input cur_mode_e m);
        if (m == M64_3C) begin
            in_span = !d[13] && (d[12:6] == 7'h00);
        end else begin
            in_span = !d[13] && (d[12:7] == 6'h00);
        end
    endfunction : in_span

    function automatic logic [23:0] fetch_addr(input logic [11:0] base,
        input logic [5:0] cfg, input logic [6:0] row, input logic [1:0] w);
        if (mode_of(cfg) == M64_3C) begin
            fetch_addr = {base, cfg[`CFG_PAT_LSB +: 2], // [RULE_01] [RULE_15]
                row[5:0], w, 2'h0}; // [RULE_02]
        end else begin
            fetch_addr = {base, cfg[`CFG_PAT_LSB], // [RULE_04] [RULE_08] [RULE_15]
                row, w, 2'h0}; // [RULE_05]
        end
    endfunction : fetch_addr

    // ------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------
    cursor_s s_q;
    cursor_s s_d;
    pix_if px [2] ();
    logic req;
    logic hit;
    logic cs;
    logic [2:0] sub;
    logic wr;
    logic [1:0] pw;
    logic [1:0][4:0] bit_sel;
    logic [1:0][1:0] wsel;
    logic [1:0] on_px;

    assign req = cyc_i && stb_i;
    assign hit = (adr_i[7:6] == 2'h0);
    assign cs = adr_i[`CUR_SEL_BIT];
    assign sub = adr_i[4:2];
    // a write lands on the edge where the master sees ack
    assign wr = req && we_i && s_q.ack && hit;
    assign pw = sub[1:0];

    for (genvar c = 0; c < 2; c++) begin : g_dec
        logic signed [13:0] dx;
        assign dx = rel(hpos_i, s_q.act_x[c], border_left_i, s_q.cfg[c][`CFG_ORIGIN_BIT]);
        assign on_px[c] = pix_valid_i && s_q.row_ok[c] && in_span(dx, mode_of(s_q.cfg[c]));
        assign bit_sel[c] = dx[4:0];
        assign wsel[c] = dx[6:5];
        assign px[c].mode = mode_of(s_q.cfg[c]);
        assign px[c].p0 = (mode_of(s_q.cfg[c]) == M64_3C) ?
            s_q.line[c][{1'b0, wsel[c][0]}][bit_sel[c]] : s_q.line[c][wsel[c]][bit_sel[c]];
        assign px[c].p1 = s_q.line[c][{1'b1, wsel[c][0]}][bit_sel[c]];
        cursor_decode i_cursor_decode (
            .px(px[c])
        );
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic signed [13:0] dy;
        logic [1:0] sh;
        logic [1:0][1:0] col;
        dy = 14'sh0000;
        sh = 2'h0;
        col = '0;
        s_d = s_q;
        // bus answer one cycle after the request, then drop
        s_d.ack = req && !s_q.ack;
        if (req && !s_q.ack) begin
            s_d.rdat = 32'h0000_0000;
            if (hit) begin
                case (sub)
                    `CUR_SUB_CFG: s_d.rdat = {26'h0, s_q.cfg[cs]};
                    `CUR_SUB_BASE: s_d.rdat = {8'h00, s_q.base[cs], 12'h000};
                    `CUR_SUB_ACTIVE: s_d.rdat = {4'h0, s_q.act_y[cs], 4'h0, s_q.act_x[cs]};
                    `CUR_SUB_STATUS: s_d.rdat = {29'h0, s_q.armed[cs], s_q.seq[cs]};
                    default: s_d.rdat = {24'h0, s_q.pend[cs][pw]};
                endcase
            end
        end
        // position moves at vsync only when a full sequence is armed
        for (int c = 0; c < 2; c++) begin
            if (vsync_i && s_q.armed[c]) begin
                s_d.act_x[c] = {s_q.pend[c][1][3:0], s_q.pend[c][0]}; // [RULE_12] [RULE_14]
                s_d.act_y[c] = {s_q.pend[c][3][3:0], s_q.pend[c][2]}; // [RULE_12] [RULE_14]
                s_d.armed[c] = 1'b0;
            end
        end
        if (wr) begin
            case (sub)
                `CUR_SUB_CFG: begin
                    if (sel_i[0]) begin
                        s_d.cfg[cs] = dat_i[`CFG_WIDTH-1:0];
                    end
                end
                `CUR_SUB_BASE: begin
                    if (sel_i[1]) begin
                        s_d.base[cs][3:0] = dat_i[15:12];
                    end
                    if (sel_i[2]) begin
                        s_d.base[cs][11:4] = dat_i[23:16];
                    end
                end
                `CUR_SUB_ACTIVE, `CUR_SUB_STATUS: begin
                    s_d.base[cs] = s_q.base[cs];
                end
                default: begin
                    if (sel_i[0]) begin
                        s_d.pend[cs][pw] = pw[0] ? (dat_i[7:0] & `HI_BYTE_MASK) // [RULE_09]
                            : dat_i[7:0];
                        // the set of a completed sequence wins over the vsync clear
                        if (pw == 2'h0) begin
                            s_d.seq[cs] = 2'h1; // [RULE_16]
                            s_d.armed[cs] = 1'b0;
                        end else if (pw == s_q.seq[cs] && pw == 2'h3) begin
                            s_d.seq[cs] = 2'h0;
                            s_d.armed[cs] = 1'b1; // [RULE_14]
                        end else if (pw == s_q.seq[cs]) begin
                            s_d.seq[cs] = pw + 2'h1; // [RULE_13]
                        end else begin
                            s_d.seq[cs] = 2'h0; // [RULE_16]
                            s_d.armed[cs] = 1'b0; // [RULE_16]
                        end
                    end
                end
            endcase
        end
        // line fetch; assumed to finish within horizontal blanking
        case (s_q.fst)
            F_IDLE: begin
                s_d.fst = F_IDLE;
            end
            F_RUN: begin
                if (!s_q.row_ok[s_q.fc] || mem_ack_i) begin
                    if (s_q.row_ok[s_q.fc]) begin
                        s_d.line[s_q.fc][s_q.fw] = mem_data_i;
                    end
                    s_d.fw = s_q.fw + 2'h1;
                    if (s_q.fw == 2'h3 || !s_q.row_ok[s_q.fc]) begin
                        s_d.fw = 2'h0;
                        s_d.fc = 1'b1;
                        s_d.fst = s_q.fc ? F_IDLE : F_RUN;
                    end
                end
            end
            default: s_d.fst = F_IDLE;
        endcase
        if (line_start_i) begin
            for (int c = 0; c < 2; c++) begin
                dy = rel(vpos_i, s_q.act_y[c], border_top_i, s_q.cfg[c][`CFG_ORIGIN_BIT]);
                s_d.row_ok[c] = s_q.cfg[c][`CFG_EN_BIT] && mode_of(s_q.cfg[c]) != M_RSV &&
                    in_span(dy, mode_of(s_q.cfg[c]));
                s_d.row[c] = dy[6:0];
            end
            s_d.fst = F_RUN;
            s_d.fc = 1'b0;
            s_d.fw = 2'h0;
        end
        // pixel overlay, cursor 1 on top of cursor 2
        sh[0] = on_px[0] && px[0].show;
        sh[1] = on_px[1] && px[1].show;
        col[0] = px[0].color;
        col[1] = px[1].color;
        s_d.show = sh[0] || sh[1];
        s_d.color = sh[0] ? col[0] : col[1];
        if (rst_i) begin
            s_d = '0;
            s_d.fst = F_IDLE;
            for (int c = 0; c < 2; c++) begin
                s_d.cfg[c] = `CFG_RESET;
                s_d.base[c] = `BASE_RESET;
                s_d.act_x[c] = `POS_RESET;
                s_d.act_y[c] = `POS_RESET;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    assign ack_o = s_q.ack;
    assign dat_o = s_q.rdat;
    assign mem_req_o = (s_q.fst == F_RUN) && s_q.row_ok[s_q.fc];
    assign mem_addr_o = fetch_addr(s_q.base[s_q.fc], s_q.cfg[s_q.fc], s_q.row[s_q.fc], s_q.fw);
    assign cur_show_o = s_q.show;
    assign cur_color_o = s_q.color;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic pos_wr;
    assign pos_wr = wr && sel_i[0] && sub[2];

    property p_bus_ack;
        @(posedge clk_i) disable iff (rst_i) req && !ack_o |=> ack_o ##1 !ack_o;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("ack not one cycle after request");

    property p_seq_restart;
        @(posedge clk_i) disable iff (rst_i)
            pos_wr && pw == 2'h0 |=> s_q.seq[$past(cs)] == 2'h1 && !s_q.armed[$past(cs)];
    endproperty
    a_seq_restart: assert property (p_seq_restart) // [RULE_16]
        else $error("first byte did not restart");

    property p_arm;
        @(posedge clk_i) disable iff (rst_i)
            pos_wr && pw == 2'h3 && s_q.seq[cs] == 2'h3 |=> s_q.armed[$past(cs)];
    endproperty
    a_arm: assert property (p_arm) else $error("complete sequence not armed"); // [RULE_14]

    property p_ooo;
        @(posedge clk_i) disable iff (rst_i)
            pos_wr && pw != 2'h0 && pw != s_q.seq[cs] |=> !s_q.armed[$past(cs)];
    endproperty
    a_ooo: assert property (p_ooo) else $error("broken sequence still armed"); // [RULE_16]

    property p_move;
        @(posedge clk_i) disable iff (rst_i)
            vsync_i && s_q.armed[0] |=>
                s_q.act_x[0] == {$past(s_q.pend[0][1][3:0]), $past(s_q.pend[0][0])};
    endproperty
    a_move: assert property (p_move) else $error("armed position not moved at vsync"); // [RULE_12]

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
            !(vsync_i && s_q.armed[1]) |=> $stable(s_q.act_y[1]) && $stable(s_q.act_x[1]);
    endproperty
    a_hold: assert property (p_hold) else $error("position changed outside vsync"); // [RULE_14]

    property p_addr64;
        @(posedge clk_i) disable iff (rst_i) mem_req_o && mode_of(s_q.cfg[s_q.fc]) == M64_3C |->
            mem_addr_o[11:10] == s_q.cfg[s_q.fc][`CFG_PAT_LSB +: 2] && mem_addr_o[3:2] == s_q.fw;
    endproperty
    a_addr64: assert property (p_addr64) else $error("bad 64x64 fetch address"); // [RULE_02]

    property p_clear64;
        @(posedge clk_i) disable iff (rst_i)
            on_px[1] && px[1].mode == M64_3C && px[1].p0 && !px[1].p1 && !on_px[0] |=>
                !cur_show_o;
    endproperty
    a_clear64: assert property (p_clear64) else $error("transparent pixel drawn"); // [RULE_03]

    property p_two_color;
        @(posedge clk_i) disable iff (rst_i)
            on_px[0] && px[0].mode == M128_2C |=>
                cur_show_o && cur_color_o == {1'b1, $past(px[0].p0)};
    endproperty
    a_two_color: assert property (p_two_color) else $error("wrong two-colour pixel"); // [RULE_06]

    c_arm: cover property (@(posedge clk_i) disable iff (rst_i)
        pos_wr && pw == 2'h3 ##1 s_q.armed[0]);
    c_move: cover property (@(posedge clk_i) disable iff (rst_i) vsync_i && s_q.armed[0]);
    c_fetch: cover property (@(posedge clk_i) disable iff (rst_i) mem_req_o && mem_ack_i);
endmodule : cursor_core

// ### cursor_mem_model.sv
// frame memory model that answers cursor pattern fetches
`timescale 1ns/10ps
module cursor_mem_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic [23:0] addr_i,
    input wire logic slow_i,
    output logic ack_o,
    output logic [31:0] data_o
);
    // ------------------------------------------------------------
    // stored words
    // ------------------------------------------------------------
    // same four words in every line: each plane pair value shows up
    localparam logic [3:0][31:0] PAT = {32'h5555_5555, 32'haaaa_aaaa, 32'h3333_3333,
        32'hcccc_cccc};
    logic [1:0] wait_q;

    // ------------------------------------------------------------
    // answer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        ack_o <= 1'b0;
        // released bus never holds the last word, so stale reads show
        data_o <= ~data_o;
        if (rst_i) begin
            wait_q <= 2'h0;
            data_o <= 32'h0;
        end else if (req_i && !ack_o) begin
            if (!slow_i || wait_q == 2'h3) begin
                ack_o <= 1'b1;
                data_o <= PAT[addr_i[3:2]];
                wait_q <= 2'h0;
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule : cursor_mem_model

// ### hw_cursor_pattern_position_bench.sv
// self-checking bench for the two hardware cursors
`timescale 1ns/10ps
module hw_cursor_pattern_position_bench;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic vsync_i = 1'b0, line_start_i = 1'b0, pix_valid_i = 1'b0, slow = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [11:0] hpos_i = 12'h000, vpos_i = 12'h000;
    logic [11:0] border_left_i = 12'h010, border_top_i = 12'h008;
    logic [31:0] dat_o, mem_data, rd;
    logic ack_o, mem_req, mem_ack, cur_show_o;
    logic [1:0] cur_color_o;
    logic [23:0] mem_addr;
    logic [23:0] q[$];
    int err_count = 0, n_compared = 0;

    cursor_core i_cursor_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .vsync_i(vsync_i), .line_start_i(line_start_i),
        .pix_valid_i(pix_valid_i), .hpos_i(hpos_i), .vpos_i(vpos_i),
        .border_left_i(border_left_i), .border_top_i(border_top_i), .mem_req_o(mem_req),
        .mem_addr_o(mem_addr), .mem_ack_i(mem_ack), .mem_data_i(mem_data),
        .cur_show_o(cur_show_o), .cur_color_o(cur_color_o));
    cursor_mem_model i_cursor_mem_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_req),
        .addr_i(mem_addr), .slow_i(slow), .ack_o(mem_ack), .data_o(mem_data));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (mem_req === 1'b1 && mem_ack === 1'b1) q.push_back(mem_addr);
    end

    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        if (n >= 20) chk(32'h0, 32'h1, "bus answer missing");
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask : rdchk

    task automatic pulse_vsync;
        @(posedge clk_i);
        vsync_i <= 1'b1;
        @(posedge clk_i);
        vsync_i <= 1'b0;
        @(posedge clk_i);
    endtask : pulse_vsync

    task automatic wr4(input logic [7:0] c, input logic [11:0] x, input logic [11:0] y);
        wb(1'b1, c + 8'h10, {24'h0, x[7:0]});
        wb(1'b1, c + 8'h14, {28'h0, x[11:8]});
        wb(1'b1, c + 8'h18, {24'h0, y[7:0]});
        wb(1'b1, c + 8'h1c, {28'h0, y[11:8]});
    endtask : wr4

    task automatic line(input logic [11:0] v, input logic [23:0] a0);
        int n;
        n = 0;
        q.delete();
        @(posedge clk_i);
        vpos_i <= v;
        line_start_i <= 1'b1;
        @(posedge clk_i);
        line_start_i <= 1'b0;
        while (q.size() < 4 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        repeat (2) @(posedge clk_i);
        chk(q.size(), 32'h4, "fetch count");
        for (int i = 0; i < q.size() && i < 4; i++) begin
            chk({8'h0, q[i]}, {8'h0, a0} + 32'h4 * i, "fetch address");
        end
    endtask : line

    // e is {show, colour}; colour is only judged where the cursor shows
    task automatic pix(input logic [11:0] h, input logic [2:0] e);
        @(posedge clk_i);
        hpos_i <= h;
        pix_valid_i <= 1'b1;
        @(posedge clk_i);
        pix_valid_i <= 1'b0;
        #1;
        if (e[2]) chk({29'h0, cur_show_o, cur_color_o}, {29'h0, e}, "pixel");
        else chk({31'h0, cur_show_o}, 32'h0, "pixel hidden");
    endtask : pix

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rdchk(8'h00, 32'h0, "config after reset");
        rdchk(8'h08, 32'h0, "active after reset");
        wb(1'b1, 8'h40, 32'hffff_ffff);
        rdchk(8'h40, 32'h0, "unmapped read");
        rdchk(8'h00, 32'h0, "config untouched");
        wb(1'b1, 8'h00, 32'h0000_003f);
        rdchk(8'h00, 32'h0000_003f, "config fields");
        wb(1'b1, 8'h00, 32'h0);
    endtask : t_regs

    task automatic t_seq;
        wr4(8'h00, 12'hfff, 12'hf34);
        rdchk(8'h14, 32'h0000_000f, "high byte");
        wb(1'b0, 8'h0c, 32'h0);
        chk({31'h0, rd[2]}, 32'h1, "armed");
        rdchk(8'h08, 32'h0, "held until vsync");
        pulse_vsync();
        rdchk(8'h08, 32'h0f34_0fff, "moved at vsync");
        wb(1'b1, 8'h10, 32'h11);
        wb(1'b1, 8'h18, 32'h22);
        rdchk(8'h0c, 32'h0, "skipped byte");
        pulse_vsync();
        rdchk(8'h08, 32'h0f34_0fff, "kept after skip");
        wr4(8'h00, 12'h001, 12'h002);
        wb(1'b1, 8'h14, 32'hff);
        rdchk(8'h0c, 32'h0, "broken after complete");
        rdchk(8'h14, 32'h0000_000f, "high byte masked");
        pulse_vsync();
        rdchk(8'h08, 32'h0f34_0fff, "kept after break");
        wr4(8'h00, 12'h001, 12'h002);
        pulse_vsync();
        rdchk(8'h08, 32'h0002_0001, "restarted sequence");
    endtask : t_seq

    // cursor 2 measured from the active area: border added to position
    task automatic t_pix64;
        wb(1'b1, 8'h24, 32'h0012_3000);
        wb(1'b1, 8'h20, 32'h0000_0021);
        wr4(8'h20, 12'h064, 12'h032);
        pulse_vsync();
        line(12'h03d, 24'h123830);
        pix(12'h074, 3'b100);
        pix(12'h075, 3'b101);
        pix(12'h076, 3'b000);
        pix(12'h077, 3'b111);
        pix(12'h094, 3'b111);
        pix(12'h096, 3'b101);
        pix(12'h073, 3'b000);
        pix(12'h0b4, 3'b000);
        wb(1'b1, 8'h20, 32'h0);
    endtask : t_pix64

    // cursor 1 at x = -32 from the border corner, pattern 1
    task automatic t_pix128(input logic [5:0] cfg, input logic [2:0] e1, input logic [2:0] e0);
        slow <= (cfg[2:1] == 2'h2);
        wb(1'b1, 8'h04, 32'h0045_6000);
        wb(1'b1, 8'h00, {26'h0, cfg});
        wr4(8'h00, 12'hfe0, 12'h00a);
        pulse_vsync();
        line(12'h00f, 24'h456850);
        pix(12'h000, e1);
        pix(12'h020, e0);
        pix(12'h040, e1);
        pix(12'h05f, e0);
        pix(12'h060, 3'b000);
    endtask : t_pix128

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_seq();
        t_pix64();
        t_pix128(6'h1b, 3'b111, 3'b110);
        t_pix128(6'h1d, 3'b110, 3'b000);
        results();
    end

    initial begin
        #200000;
        err_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        results();
    end
endmodule : hw_cursor_pattern_position_bench
